// file: shared/tcs_pkg.sv
// Constants, register map and pin carrier for the timing control/status block.
// Assumes a single 200 MHz core clock; all pin levels arrive asynchronously.
package tcs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RST_MIN_NS = 300;
   localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Wait after release until the synchronised mode pins are valid
   localparam logic [1:0] INIT_CYC = 2'h3;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE = 8'h1F;
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   localparam logic [7:0] ADDR_STAT = 8'h21;
   localparam logic [7:0] ADDR_ISR = 8'h22;
   localparam logic [7:0] ADDR_IEN = 8'h23;
   localparam int CTRL_FOLLOW_VAL = 0;
   localparam int CTRL_FOLLOW_OVR = 1;
   localparam int EV_LOCK = 0;
   localparam int EV_HOLD = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [1:0] ISR_RST = 2'h0;
   localparam logic [1:0] IEN_RST = 2'h0;

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   // Upper six bits of the two-wire bus address, arbitrary value
   localparam logic [5:0] I2C_ADDR_HI = 6'h2A;
   localparam logic [8:0] PIN_RST = 9'h1FF;

   typedef enum logic [1:0] {
      MODE_AUTO = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_HOLDOVER = 2'b10,
      MODE_FREERUN = 2'b11
   } tcs_mode_e;

   localparam tcs_mode_e MODE_RST = MODE_FREERUN;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_REG = 3'b010,
      I2C_WDATA = 3'b011,
      I2C_TX = 3'b100
   } tcs_i2c_e;

   typedef struct packed {
      logic [1:0] mode;
      logic follower;
      logic diff0;
      logic diff1;
      logic i2c_sel;
      logic sck;
      logic sda;
      logic cs_n;
   } tcs_pins_s;

endpackage : tcs_pkg

// file: core/tcs_sync.sv
// Two-flop level synchroniser, vector wide.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ps
module tcs_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_q <= RST;
         q <= RST;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : tcs_sync

// file: core/tcs_top.sv
// Control pins, status pins, interrupt pin and shared serial host port.
// Assumes loop status comes from core logic on the same clock.
`timescale 1ns/1ps
// How it works
// [RULE_01] Mode pins are captured as default loop mode right after reset.
// [RULE_02] Later, mode follows pin changes or writes to the mode register.
// [RULE_03] Follower pin high selects follower, low selects master.
// [RULE_04] A control register can override the follower pin.
// [RULE_05] Each differential output is driven when its enable is high.
// [RULE_06] Lock flag output high while the loop is locked.
// [RULE_07] Holdover flag output high while the loop is in holdover.
// [RULE_08] Interface select high enables two-wire port, low enables SPI.
// [RULE_09] Clock pin is SPI clock or two-wire clock by interface select.
// [RULE_10] Data pin is SPI input or two-wire data by interface select.
// [RULE_11] Serial output carries SPI read data, idle low in two-wire mode.
// [RULE_12] Select pin is SPI chip select or two-wire address bit 0.
// [RULE_13] Status changes pull the open-drain interrupt low until serviced; the code pulls it only for events enabled in the IEN register.
// [RULE_14] Host holds reset low at least 300 ns after power-up.
// [RULE_15] All control pins pass a two-flop synchroniser first.
module tcs_top
   import tcs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Control pins
   input wire logic [1:0] primary_loop_mode_pin,
   input wire logic follower_pin,
   input wire logic diff_out0_enable,
   input wire logic diff_out1_enable,
   input wire logic i2c_select_pin,
   // Loop core
   input wire logic loop_locked_in,
   input wire logic loop_holdover_in,
   output tcs_mode_e primary_loop_mode,
   output logic follower_mode,
   output logic diff_out0_drive,
   output logic diff_out1_drive,
   // Status pins
   output logic loop_locked_flag,
   output logic loop_holdover_flag,
   output logic interrupt_n_o,
   output logic interrupt_n_oe,
   // Serial pins
   input wire logic sck_scl_i,
   output logic sck_scl_o,
   output logic sck_scl_oe,
   input wire logic si_sda_i,
   output logic si_sda_o,
   output logic si_sda_oe,
   output logic so,
   input wire logic select_or_addr_bit0
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   tcs_pins_s pins;
   logic [8:0] pins_raw;
   logic [8:0] pins_vec;
   assign pins_raw = {primary_loop_mode_pin, follower_pin, diff_out0_enable, diff_out1_enable,
                      i2c_select_pin, sck_scl_i, si_sda_i, select_or_addr_bit0};
   assign pins = tcs_pins_s'(pins_vec);

   tcs_sync #(.W(9), .RST(PIN_RST)) u_sync (  // RULE_15
      .clock(clock),
      .arst_n(arst_n),
      .d(pins_raw),
      .q(pins_vec)
   );

   logic sck_prev_q;
   logic sda_prev_q;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sck_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         sck_prev_q <= pins.sck;
         sda_prev_q <= pins.sda;
      end
   end

   wire i2c_on = pins.i2c_sel;  // RULE_08
   wire sck_rise = pins.sck & ~sck_prev_q;
   wire sck_fall = ~pins.sck & sck_prev_q;
   wire spi_act = ~i2c_on & ~pins.cs_n;  // RULE_12
   wire i2c_start = i2c_on & pins.sck & sck_prev_q & sda_prev_q & ~pins.sda;
   wire i2c_stop = i2c_on & pins.sck & sck_prev_q & ~sda_prev_q & pins.sda;
   wire [6:0] i2c_addr = {I2C_ADDR_HI, pins.cs_n};  // RULE_12

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   tcs_mode_e mode_q;
   logic [1:0] ctrl_q;
   logic [1:0] isr_q;
   logic [1:0] ien_q;
   logic [1:0] pin_mode_prev_q;
   logic [1:0] init_q;
   logic init_done_q;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   function automatic logic [7:0] rd_f(input logic [7:0] a);
      if (a == ADDR_MODE) rd_f = {6'h00, mode_q};
      else if (a == ADDR_CTRL) rd_f = {6'h00, ctrl_q};
      else if (a == ADDR_STAT) rd_f = {6'h00, loop_holdover_flag, loop_locked_flag};
      else if (a == ADDR_ISR) rd_f = {6'h00, isr_q};
      else if (a == ADDR_IEN) rd_f = {6'h00, ien_q};
      else rd_f = 8'h00;
   endfunction : rd_f

   wire wr_mode = wr_en & (wr_addr == ADDR_MODE);
   wire wr_ctrl = wr_en & (wr_addr == ADDR_CTRL);
   wire wr_isr = wr_en & (wr_addr == ADDR_ISR);
   wire wr_ien = wr_en & (wr_addr == ADDR_IEN);
   wire pin_mode_chg = init_done_q & (pins.mode != pin_mode_prev_q);
   wire [1:0] events = {loop_holdover_in ^ loop_holdover_flag, loop_locked_in ^ loop_locked_flag};

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         init_q <= 2'h0;
         init_done_q <= 1'b0;
         mode_q <= MODE_RST;
         pin_mode_prev_q <= MODE_RST;
      end
      else
      begin
         pin_mode_prev_q <= pins.mode;
         if (!init_done_q)
         begin
            init_q <= init_q + 2'h1;
            if (init_q == INIT_CYC)
            begin
               init_done_q <= 1'b1;
               mode_q <= tcs_mode_e'(pins.mode);  // RULE_01
            end
         end
         else if (wr_mode)
            mode_q <= tcs_mode_e'(wr_data[1:0]);  // RULE_02
         else if (pin_mode_chg)
            mode_q <= tcs_mode_e'(pins.mode);  // RULE_02
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_q <= CTRL_RST;
         ien_q <= IEN_RST;
         isr_q <= ISR_RST;
         loop_locked_flag <= 1'b0;
         loop_holdover_flag <= 1'b0;
         diff_out0_drive <= 1'b0;
         diff_out1_drive <= 1'b0;
         follower_mode <= 1'b0;
      end
      else
      begin
         if (wr_ctrl) ctrl_q <= wr_data[1:0];
         if (wr_ien) ien_q <= wr_data[1:0];
         // Write-one-to-clear; a new event in the same cycle survives
         isr_q <= (isr_q & ~(wr_isr ? wr_data[1:0] : 2'h0)) | events;  // RULE_13
         loop_locked_flag <= loop_locked_in;  // RULE_06
         loop_holdover_flag <= loop_holdover_in;  // RULE_07
         diff_out0_drive <= pins.diff0;  // RULE_05
         diff_out1_drive <= pins.diff1;  // RULE_05
         follower_mode <= ctrl_q[CTRL_FOLLOW_OVR] ? ctrl_q[CTRL_FOLLOW_VAL]  // RULE_04
                                                  : pins.follower;  // RULE_03
      end
   end

   assign primary_loop_mode = mode_q;
   assign interrupt_n_o = 1'b0;
   assign interrupt_n_oe = |(isr_q & ien_q);  // RULE_13

   // ----------------------------------------------------------------
   // SPI slave: command byte {read, addr[6:0]}, then one data byte
   // ----------------------------------------------------------------
   logic [3:0] spi_cnt_q;
   logic [6:0] spi_sh_q;
   logic [7:0] spi_cmd_q;
   logic [7:0] spi_tx_q;
   logic so_q;
   wire [7:0] spi_byte = {spi_sh_q, pins.sda};  // RULE_10
   wire spi_wr = spi_act & sck_rise & (spi_cnt_q == 4'hF) & ~spi_cmd_q[7];

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spi_cnt_q <= 4'h0;
         spi_sh_q <= 7'h00;
         spi_cmd_q <= 8'h00;
         spi_tx_q <= 8'h00;
         so_q <= 1'b0;
      end
      else if (!spi_act)
      begin
         spi_cnt_q <= 4'h0;
         so_q <= 1'b0;
      end
      else if (sck_rise)  // RULE_09
      begin
         spi_sh_q <= spi_byte[6:0];
         spi_cnt_q <= spi_cnt_q + 4'h1;
         if (spi_cnt_q == 4'h7)
         begin
            spi_cmd_q <= spi_byte;
            spi_tx_q <= rd_f({1'b0, spi_byte[6:0]});
         end
      end
      else if (sck_fall && spi_cnt_q[3] && spi_cmd_q[7])
         so_q <= spi_tx_q[~spi_cnt_q[2:0]];  // RULE_11
   end

   assign so = so_q & ~i2c_on;  // RULE_11

   // ----------------------------------------------------------------
   // Two-wire slave: address, register pointer, data bytes
   // ----------------------------------------------------------------
   // No clock stretching, so the clock line is only ever sampled
   tcs_i2c_e ist_q;
   logic [3:0] icnt_q;
   logic [7:0] ish_q;
   logic [7:0] iptr_q;
   logic [7:0] itx_q;
   logic iack_q;
   logic sda_oe_q;
   wire i_rx = (ist_q == I2C_ADDR) | (ist_q == I2C_REG) | (ist_q == I2C_WDATA);
   wire i_match = (ish_q[7:1] == i2c_addr);
   wire i2c_wr = i2c_on & sck_fall & ~iack_q & (icnt_q == 4'h8) & (ist_q == I2C_WDATA);

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ist_q <= I2C_IDLE;
         icnt_q <= 4'h0;
         ish_q <= 8'h00;
         iptr_q <= 8'h00;
         itx_q <= 8'h00;
         iack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else if (!i2c_on || i2c_stop)
      begin
         ist_q <= I2C_IDLE;
         iack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else if (i2c_start)
      begin
         ist_q <= I2C_ADDR;
         icnt_q <= 4'h0;
         iack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else if (sck_rise && !iack_q)
      begin
         icnt_q <= icnt_q + 4'h1;
         if (i_rx)
            ish_q <= {ish_q[6:0], pins.sda};  // RULE_10
         else if (ist_q == I2C_TX && icnt_q == 4'h8)
         begin
            icnt_q <= 4'h0;
            if (pins.sda)
               ist_q <= I2C_IDLE;
            else
            begin
               itx_q <= rd_f(iptr_q + 8'h01);
               iptr_q <= iptr_q + 8'h01;
            end
         end
      end
      else if (sck_fall)
      begin
         if (iack_q)
         begin
            iack_q <= 1'b0;
            icnt_q <= 4'h0;
            sda_oe_q <= (ist_q == I2C_TX) & ~itx_q[7];
         end
         else if (i_rx && icnt_q == 4'h8)
         begin
            iack_q <= (ist_q != I2C_ADDR) | i_match;
            sda_oe_q <= (ist_q != I2C_ADDR) | i_match;
            if (ist_q == I2C_ADDR)
            begin
               ist_q <= !i_match ? I2C_IDLE : (ish_q[0] ? I2C_TX : I2C_REG);
               itx_q <= rd_f(iptr_q);
            end
            else if (ist_q == I2C_REG)
            begin
               iptr_q <= ish_q;
               ist_q <= I2C_WDATA;
            end
            else
               iptr_q <= iptr_q + 8'h01;
         end
         else if (ist_q == I2C_TX)
            sda_oe_q <= (icnt_q < 4'h8) & ~itx_q[~icnt_q[2:0]];
      end
   end

   assign si_sda_o = 1'b0;
   assign si_sda_oe = sda_oe_q & i2c_on;  // RULE_10
   assign sck_scl_o = 1'b0;
   assign sck_scl_oe = 1'b0;  // RULE_09
   assign wr_en = spi_wr | i2c_wr;  // RULE_08
   assign wr_addr = i2c_on ? iptr_q : {1'b0, spi_cmd_q[6:0]};
   assign wr_data = i2c_on ? ish_q : spi_byte;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_init_end;
      !init_done_q ##1 init_done_q;
   endsequence

   sequence s_ovr_off;
      !ctrl_q[CTRL_FOLLOW_OVR] ##1 !ctrl_q[CTRL_FOLLOW_OVR];
   endsequence

   sequence s_ovr_on;
      ctrl_q[CTRL_FOLLOW_OVR] ##1 ctrl_q[CTRL_FOLLOW_OVR];
   endsequence

   sequence s_hold_seen;
      loop_holdover_flag ##1 isr_q[EV_HOLD];
   endsequence

   a_mode_capture: assert property (s_init_end |-> mode_q == $past(pins.mode)) // RULE_01
      else $error("mode not captured from pins at start");
   a_mode_write: assert property ( // RULE_02
      init_done_q && wr_mode |=> mode_q == $past(wr_data[1:0]))
      else $error("mode register write lost");
   a_mode_pin: assert property (pin_mode_chg && !wr_mode |=> mode_q == $past(pins.mode)) // RULE_02
      else $error("mode pin change not followed");
   a_follower_pin: assert property ( // RULE_03
      s_ovr_off |-> follower_mode == $past(pins.follower))
      else $error("follower pin not followed");
   a_follower_sw: assert property ( // RULE_04
      s_ovr_on |-> follower_mode == $past(ctrl_q[CTRL_FOLLOW_VAL]))
      else $error("follower override ignored");
   a_diff_drive: assert property ( // RULE_05
      pins.diff0 && !pins.diff1 |=> diff_out0_drive && !diff_out1_drive)
      else $error("differential enable wrong");
   a_lock_flag: assert property (loop_locked_in [*2] |=> loop_locked_flag) // RULE_06
      else $error("lock flag not high");
   a_hold_flag: assert property ($rose(loop_holdover_in) |=> s_hold_seen) // RULE_07
      else $error("holdover flag or event missing");
   a_so_quiet: assert property (i2c_on |-> !so) // RULE_11
      else $error("serial output active in two-wire mode");
   a_sda_spi: assert property (!i2c_on |-> !si_sda_oe && !sck_scl_oe) // RULE_10
      else $error("data pin driven in SPI mode");
   // Enabled status change must reach the pin, whatever a clear does
   a_int_pull: assert property ( // RULE_13
      (|(events & ien_q)) && !wr_ien |=> interrupt_n_oe && !interrupt_n_o)
      else $error("interrupt not pulled low");
   a_int_sticky: assert property (isr_q[EV_LOCK] && !wr_isr |=> isr_q[EV_LOCK]) // RULE_13
      else $error("interrupt event lost");

endmodule : tcs_top

// file: tb/tcs_host.sv
// Host processor model: master of the shared serial pins, SPI or two-wire.
// Assumes the bench resolves the open-drain data level and returns it on sda.
`timescale 1ns/1ps
module tcs_host
(
   // Serial pins
   output logic sck,
   output logic sdi,
   output logic cs_n,
   input wire logic so,
   input wire logic sda
);
   // ----------------------------------------------------------------
   // Link timing, 64 ns serial clock, still between frames
   // ----------------------------------------------------------------
   localparam int HALF = 32;

   initial
   begin
      sck = 1'b0;
      sdi = 1'b1;
      cs_n = 1'b1;
   end

   // Mode 0 frame; reply bits taken just before each of the last eight rises
   task automatic spi(input logic [15:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         sdi = tx[i];
         #HALF;
         if (i < 8) rx[i] = so;
         sck = 1'b1;
         #HALF;
         sck = 1'b0;
      end
      #HALF;
      cs_n = 1'b1;
      // Released line must not keep showing the last bit
      sdi = ~sdi;
      #(2 * HALF);
   endtask : spi

   // Also serves as repeated start
   task automatic i2c_start();
      sdi = 1'b1;
      #HALF;
      sck = 1'b1;
      #HALF;
      sdi = 1'b0;
      #HALF;
      sck = 1'b0;
   endtask : i2c_start

   task automatic i2c_stop();
      sdi = 1'b0;
      #HALF;
      sck = 1'b1;
      #HALF;
      sdi = 1'b1;
      #(2 * HALF);
   endtask : i2c_stop

   // Ninth slot released: ack in, or nack out on reads
   task automatic i2c_byte(input logic [7:0] b, output logic [7:0] rx, output logic ack);
      rx = 8'h00;
      ack = 1'b0;
      for (int i = 8; i >= 0; i--)
      begin
         sdi = (i == 0) ? 1'b1 : b[i-1];
         #HALF;
         sck = 1'b1;
         if (i > 0) rx[i-1] = sda;
         else ack = ~sda;
         #HALF;
         sck = 1'b0;
      end
   endtask : i2c_byte
endmodule : tcs_host

// file: tb/tcs_top_tb_top.sv
// Self-checking bench for the control, status and serial host pins.
// Assumes the host model drives the serial pins; open drain resolved here.
`timescale 1ns/1ps
module tcs_top_tb_top
   import tcs_pkg::*;
   ;
   logic clock;
   logic arst_n;
   logic [1:0] mode_pin;
   logic follower_pin, diff0, diff1, i2c_sel, locked, holdover;
   tcs_mode_e mode;
   logic follower_mode, drv0, drv1, lock_f, hold_f, int_o, int_oe;
   logic scl_o, scl_oe, sda_o, sda_oe, so;
   wire sck, sdi, cs_n;
   // Open drain: a driven line shows the drive level, else the pull-up
   wire sck_i = sck & (~scl_oe | scl_o);
   wire sda_i = sdi & (~sda_oe | sda_o);
   int n_mismatch;
   int comparisons;
   logic [7:0] rx;
   logic ack;

   tcs_top dut_u (.clock(clock), .arst_n(arst_n), .primary_loop_mode_pin(mode_pin),
      .follower_pin(follower_pin), .diff_out0_enable(diff0), .diff_out1_enable(diff1),
      .i2c_select_pin(i2c_sel), .loop_locked_in(locked), .loop_holdover_in(holdover),
      .primary_loop_mode(mode), .follower_mode(follower_mode), .diff_out0_drive(drv0),
      .diff_out1_drive(drv1), .loop_locked_flag(lock_f), .loop_holdover_flag(hold_f),
      .interrupt_n_o(int_o), .interrupt_n_oe(int_oe), .sck_scl_i(sck_i),
      .sck_scl_o(scl_o), .sck_scl_oe(scl_oe), .si_sda_i(sda_i), .si_sda_o(sda_o),
      .si_sda_oe(sda_oe), .so(so), .select_or_addr_bit0(cs_n));
   tcs_host host_u (.sck(sck), .sdi(sdi), .cs_n(cs_n), .so(so), .sda(sda_i));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   // Reset held for exactly the minimum the device needs after power-up
   task automatic rst(input logic [1:0] m);
      arst_n = 1'b0;
      mode_pin = m;
      cyc(RST_MIN_CYC);
      arst_n = 1'b1;
      cyc(8);
   endtask : rst

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.spi({1'b0, a[6:0], d}, rx);
      cyc(1);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host_u.spi({1'b1, a[6:0], 8'h00}, rx);
      chk(rx, exp);
      cyc(1);
   endtask : rd

   task automatic ib(input logic [7:0] b, input logic exp_ack);
      host_u.i2c_byte(b, rx, ack);
      chk_bit(ack, exp_ack);
   endtask : ib

   // ----------------------------------------------------------------
   // Clock, watchdog, main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial
   begin
      #100000;
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      {mode_pin, follower_pin, diff0, diff1, i2c_sel, locked, holdover} = '0;
      arst_n = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      for (int m = 0; m < 4; m++)
      begin
         rst(m[1:0]);
         chk({6'h00, mode}, m[7:0]);
      end
      mode_pin = 2'h1;
      cyc(5);
      chk({6'h00, mode}, 8'h01);
      wr(ADDR_MODE, 8'h02);
      chk({6'h00, mode}, 8'h02);
      rd(ADDR_MODE, 8'h02);
      follower_pin = 1'b1;
      cyc(5);
      chk_bit(follower_mode, 1'b1);
      follower_pin = 1'b0;
      cyc(5);
      chk_bit(follower_mode, 1'b0);
      wr(ADDR_CTRL, 8'h03);
      chk_bit(follower_mode, 1'b1);
      rd(ADDR_CTRL, 8'h03);
      follower_pin = 1'b1;
      wr(ADDR_CTRL, 8'h02);
      chk_bit(follower_mode, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         {diff1, diff0} = k[1:0];
         cyc(5);
         chk({6'h00, drv1, drv0}, k[7:0]);
      end
      // Status events, masked first, then enabled and cleared
      locked = 1'b1;
      cyc(3);
      chk_bit(lock_f, 1'b1);
      chk_bit(int_oe, 1'b0);
      rd(ADDR_STAT, 8'h01);
      rd(ADDR_ISR, 8'h01);
      wr(ADDR_IEN, 8'h01);
      chk_bit(int_oe, 1'b1);
      chk_bit(int_o, 1'b0);
      wr(ADDR_ISR, 8'h01);
      chk_bit(int_oe, 1'b0);
      holdover = 1'b1;
      cyc(3);
      chk_bit(hold_f, 1'b1);
      rd(ADDR_ISR, 8'h02);
      chk_bit(int_oe, 1'b0);
      // Lock lost with its event enabled: the pin must be pulled
      locked = 1'b0;
      cyc(3);
      chk_bit(lock_f, 1'b0);
      chk_bit(int_oe, 1'b1);
      rd(ADDR_ISR, 8'h03);
      rd(8'h40, 8'h00);
      // Two-wire port, address bit 0 held low on the shared select pin
      i2c_sel = 1'b1;
      host_u.cs_n = 1'b0;
      cyc(5);
      host_u.i2c_start();
      ib({I2C_ADDR_HI, 2'b10}, 1'b0);
      host_u.i2c_stop();
      host_u.i2c_start();
      ib({I2C_ADDR_HI, 2'b00}, 1'b1);
      ib(ADDR_MODE, 1'b1);
      ib(8'h03, 1'b1);
      // Pointer moves on to the control register: override off
      ib(8'h01, 1'b1);
      host_u.i2c_stop();
      cyc(1);
      chk({6'h00, mode}, 8'h03);
      chk_bit(follower_mode, 1'b1);
      chk_bit(so, 1'b0);
      chk_bit(scl_oe, 1'b0);
      host_u.i2c_start();
      ib({I2C_ADDR_HI, 2'b00}, 1'b1);
      ib(ADDR_MODE, 1'b1);
      host_u.i2c_start();
      ib({I2C_ADDR_HI, 2'b01}, 1'b1);
      host_u.i2c_byte(8'hFF, rx, ack);
      chk(rx, 8'h03);
      chk_bit(ack, 1'b0);
      chk_bit(so, 1'b0);
      host_u.i2c_stop();
      end_sim();
   end
endmodule : tcs_top_tb_top
